// file: pmrs_top.sv
// Power-mode and reset supervisor with an APB register slave.
// Assumes pclk is the system oscillator; pins and slow clock are asynchronous.
// What this block does
// - Operating mode keeps processor clock, slow oscillator, timer and display running.
// - Entering halt stops the processor clock, slow oscillator keeps running.
// - Halt holds the processor clock until a wake event, then resumes it.
// - Slow-clock timer and display may stay active in halt; display optional.
// - Standby stops processor clock and slow oscillator; everything inactive.
// - Standby preserves working memory and freezes all I/O pin states.
// - Low-voltage detector report asserts system reset.
// - Low-voltage reset is a build-time enable or disable.
// - Enabled supervision timer not cleared for one second asserts system reset.
// - Supervision timer counts only while the slow clock runs.
// - Processor clock is system clock divided by 1 to 64, software selected.
// - External reset pin low forces system reset.
// - Four wake sources; each wake port pin individually enabled by software.
//
// Local design decisions: the APB interface to the registers and the address map.
module pmrs_top #(
    parameter bit LVR_EN = 1'b1,
    parameter bit WDT_EN = 1'b1,
    parameter int WDT_TICKS = pmrs_pkg::WDT_TICKS_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_rst_n_pin,
    input wire logic lvd_low,
    input wire logic slow_clk,
    input wire logic [7:0] wake_port_pins,
    input wire logic [2:0] wake_evt,
    output logic cpu_clk_en,
    output logic osc32_en,
    output logic timer_en,
    output logic lcd_en,
    output logic io_hold,
    output logic ram_retain,
    output logic sys_rst_n
);
    pmrs_pkg::pmrs_state_t state, next_state;
    logic [2:0] div_sel;
    logic lcd_halt_en;
    logic [7:0] wake_pin_en;
    logic [3:0] wake_src_en;
    logic [3:0] cause;
    logic [3:0] wake_seen;
    logic [15:0] wdt_cnt;
    logic [4:0] hold_cnt;
    logic slow_prev;
    logic [7:0] pin_prev;
    logic div_tick;
    logic [10:0] sync_q;

    // Pins pass two flops before use
    pmrs_sync #(.WIDTH(pmrs_pkg::SYNC_W), .RST_VAL(pmrs_pkg::SYNC_RST)) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .d({wake_port_pins, slow_clk, lvd_low, ext_rst_n_pin}),
        .q(sync_q)
    );

    pmrs_clk_div u_div (
        .clk(pclk),
        .rst_n(presetn),
        .sel(div_sel),
        .tick(div_tick)
    );

    wire logic ext_n_s = sync_q[0];
    wire logic lvd_s = sync_q[1];
    wire logic slow_s = sync_q[2];
    wire logic [7:0] pins_s = sync_q[10:3];

    // Reset sources
    wire logic lvd_req = LVR_EN && lvd_s;
    wire logic ext_req = !ext_n_s;
    wire logic slow_tick = slow_s && !slow_prev && osc32_en;
    wire logic wdt_top = (wdt_cnt == 16'(WDT_TICKS - 1));
    wire logic wdt_fire = WDT_EN && slow_tick && wdt_top;
    wire logic rst_req = ext_req || lvd_req || (hold_cnt != 5'h00);

    // APB decode
    wire logic setup = psel && !penable;
    wire logic wr_en = psel && penable && pready && pwrite;
    wire logic hit_ctrl = (paddr == pmrs_pkg::OFS_CTRL);
    wire logic hit_mode = (paddr == pmrs_pkg::OFS_MODE);
    wire logic hit_wake = (paddr == pmrs_pkg::OFS_WAKE);
    wire logic hit_wdclr = (paddr == pmrs_pkg::OFS_WDCLR);
    wire logic hit_cause = (paddr == pmrs_pkg::OFS_CAUSE);
    wire logic hit_any = hit_ctrl || hit_mode || hit_wake || hit_wdclr || hit_cause;
    wire logic wdt_clr = wr_en && hit_wdclr;
    wire logic cmd_halt = wr_en && hit_mode && pwdata[pmrs_pkg::MODE_HALT_BIT];
    wire logic cmd_stby = wr_en && hit_mode && pwdata[pmrs_pkg::MODE_STBY_BIT];

    // Wake sources: enabled port pins falling, plus three on-chip events
    wire logic [7:0] pin_fall = pin_prev & ~pins_s & wake_pin_en;
    wire logic [3:0] wake_raw = {wake_evt, |pin_fall};
    wire logic [3:0] wake_act = wake_raw & wake_src_en;
    wire logic wake_hit = |wake_act;

    wire logic [1:0] mode_code = (state == pmrs_pkg::ST_HALT) ? pmrs_pkg::MODE_CODE_HALT :
                                 (state == pmrs_pkg::ST_STBY) ? pmrs_pkg::MODE_CODE_STBY :
                                 pmrs_pkg::MODE_CODE_OPER;
    wire logic [3:0] new_cause = {wdt_fire, lvd_req, ext_req, 1'b0};
    wire logic [31:0] rd_mux =
        hit_ctrl ? {28'h0000000, lcd_halt_en, div_sel} :
        hit_mode ? {30'h00000000, mode_code} :
        hit_wake ? {20'h00000, wake_src_en, wake_pin_en} :
        hit_wdclr ? {16'h0000, wdt_cnt} :
        hit_cause ? {24'h000000, wake_seen, cause} :
        32'h00000000;

    // Mode sequencing; commands only arrive while the processor runs
    always_comb begin
        next_state = state;
        unique case (state)
            pmrs_pkg::ST_OPER: begin
                if (cmd_stby) begin
                    next_state = pmrs_pkg::ST_STBY;
                end else if (cmd_halt) begin
                    next_state = pmrs_pkg::ST_HALT;
                end
            end
            pmrs_pkg::ST_HALT: begin
                if (wake_hit) begin
                    next_state = pmrs_pkg::ST_OPER;
                end
            end
            pmrs_pkg::ST_STBY: begin
                if (wake_hit) begin
                    next_state = pmrs_pkg::ST_OPER;
                end
            end
            // Unused fourth code falls back to operating
            default: begin
                next_state = pmrs_pkg::ST_OPER;
            end
        endcase
        if (rst_req) begin
            next_state = pmrs_pkg::ST_OPER;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= pmrs_pkg::ST_OPER;
        end else begin
            state <= next_state;
        end
    end

    // Enables follow the next state so they line up with state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_clk_en <= 1'b0;
            osc32_en <= 1'b1;
            timer_en <= 1'b1;
            lcd_en <= 1'b1;
            io_hold <= 1'b0;
            ram_retain <= 1'b0;
        end else begin
            cpu_clk_en <= (next_state == pmrs_pkg::ST_OPER) && div_tick;
            osc32_en <= (next_state != pmrs_pkg::ST_STBY);
            timer_en <= (next_state != pmrs_pkg::ST_STBY);
            lcd_en <= (next_state == pmrs_pkg::ST_OPER) ||
                      ((next_state == pmrs_pkg::ST_HALT) && lcd_halt_en);
            io_hold <= (next_state == pmrs_pkg::ST_STBY);
            ram_retain <= (next_state == pmrs_pkg::ST_STBY);
        end
    end

    // Supervision timer on slow-clock edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt <= 16'h0000;
            slow_prev <= 1'b0;
        end else begin
            slow_prev <= slow_s;
            if (rst_req || wdt_clr || wdt_fire) begin
                wdt_cnt <= 16'h0000;
            end else if (WDT_EN && slow_tick && !wdt_top) begin
                wdt_cnt <= wdt_cnt + 16'h0001;
            end
        end
    end

    // A timer reset is stretched so the core sees a clean pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 5'h00;
            sys_rst_n <= 1'b0;
        end else begin
            if (wdt_fire) begin
                hold_cnt <= 5'(pmrs_pkg::RST_HOLD_CYC);
            end else if (hold_cnt != 5'h00) begin
                hold_cnt <= hold_cnt - 5'h01;
            end
            sys_rst_n <= !rst_req;
        end
    end

    // Software registers; reset only with presetn so causes survive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_sel <= pmrs_pkg::CTRL_DIV_RST;
            lcd_halt_en <= pmrs_pkg::CTRL_LCDH_RST;
            wake_pin_en <= pmrs_pkg::WAKE_PIN_RST;
            wake_src_en <= pmrs_pkg::WAKE_SRC_RST;
        end else if (wr_en && hit_ctrl) begin
            div_sel <= pwdata[pmrs_pkg::CTRL_DIV_LSB +: 3];
            lcd_halt_en <= pwdata[pmrs_pkg::CTRL_LCDH_BIT];
        end else if (wr_en && hit_wake) begin
            wake_pin_en <= pwdata[7:0];
            wake_src_en <= pwdata[pmrs_pkg::WAKE_SRC_LSB +: 4];
        end
    end

    // Sticky flags: a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause <= 4'h0;
            wake_seen <= 4'h0;
            pin_prev <= 8'hFF;
        end else begin
            pin_prev <= pins_s;
            if (wr_en && hit_cause) begin
                cause <= (cause & ~pwdata[3:0]) | new_cause;
                wake_seen <= (wake_seen & ~pwdata[pmrs_pkg::CAUSE_WAKE_LSB +: 4]) | wake_act;
            end else begin
                cause <= cause | new_cause;
                wake_seen <= wake_seen | wake_act;
            end
        end
    end

    // Zero-wait slave; read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rd_mux;
                pslverr <= !hit_any;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_halted;
        (state == pmrs_pkg::ST_HALT) ##1 (state == pmrs_pkg::ST_HALT);
    endsequence

    property p_oper_all_on;
        (state == pmrs_pkg::ST_OPER) |-> osc32_en && timer_en && lcd_en && !io_hold;
    endproperty
    a_oper_all_on: assert property (p_oper_all_on) else $error("operating enables off");

    property p_halt_cpu_off;
        s_halted |-> !cpu_clk_en && osc32_en;
    endproperty
    a_halt_cpu_off: assert property (p_halt_cpu_off) else $error("cpu clock in halt");

    property p_halt_wake;
        (state == pmrs_pkg::ST_HALT) && wake_hit |=> (state == pmrs_pkg::ST_OPER);
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("wake not honoured");

    property p_halt_slow_on;
        (state == pmrs_pkg::ST_HALT) |-> timer_en && (lcd_en == lcd_halt_en);
    endproperty
    a_halt_slow_on: assert property (p_halt_slow_on) else $error("halt slow functions");

    property p_stby_off;
        (state == pmrs_pkg::ST_STBY) |-> !osc32_en && !lcd_en && !timer_en && !cpu_clk_en;
    endproperty
    a_stby_off: assert property (p_stby_off) else $error("standby not off");

    property p_stby_hold;
        (state == pmrs_pkg::ST_STBY) |-> io_hold && ram_retain;
    endproperty
    a_stby_hold: assert property (p_stby_hold) else $error("standby hold missing");

    property p_lvd_reset;
        lvd_req |=> !sys_rst_n;
    endproperty
    a_lvd_reset: assert property (p_lvd_reset) else $error("low voltage no reset");

    // Stretch loads one edge after the fire, so the output drops an edge later
    sequence s_stretched;
        (!sys_rst_n) [*4];
    endsequence

    property p_wdt_reset;
        wdt_fire |=> ##1 s_stretched;
    endproperty
    a_wdt_reset: assert property (p_wdt_reset) else $error("timer reset too short");

    property p_stby_no_count;
        (state == pmrs_pkg::ST_STBY) && !rst_req && !wdt_clr |=> $stable(wdt_cnt);
    endproperty
    a_stby_no_count: assert property (p_stby_no_count) else $error("timer ran in standby");

    property p_ext_reset;
        ext_req |=> !sys_rst_n && (state == pmrs_pkg::ST_OPER);
    endproperty
    a_ext_reset: assert property (p_ext_reset) else $error("pin reset ignored");

    property p_clear;
        wdt_clr |=> (wdt_cnt == 16'h0000);
    endproperty
    a_clear: assert property (p_clear) else $error("timer not cleared");

    property p_wdt_absent;
        !WDT_EN |-> (hold_cnt == 5'h00);
    endproperty
    a_wdt_absent: assert property (p_wdt_absent) else $error("absent timer fired");

    property p_cpu_oper;
        cpu_clk_en |-> (state == pmrs_pkg::ST_OPER);
    endproperty
    a_cpu_oper: assert property (p_cpu_oper) else $error("cpu clock off mode");

    property p_halt_stay;
        (state == pmrs_pkg::ST_HALT) && !wake_hit && !rst_req |=>
            (state == pmrs_pkg::ST_HALT);
    endproperty
    a_halt_stay: assert property (p_halt_stay) else $error("halt left early");

    property p_reset_zero;
        rst_req |=> (wdt_cnt == 16'h0000);
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("timer kept count");
endmodule // pmrs_top

// file: pmrs_pkg.sv
// Constants for the power-mode and reset supervisor.
// Assumes a 10 MHz pclk and a 32768 Hz slow clock sampled as a plain input.
package pmrs_pkg;
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SLOW_HZ = 32768;
    // One second without a clear
    localparam int WDT_TIMEOUT_S = 1;
    localparam int WDT_TICKS_DEF = WDT_TIMEOUT_S * SLOW_HZ;
    // Least width of a stretched timer reset
    localparam int RST_HOLD_NS = 1600;
    localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_PINS = 8;
    localparam int WAKE_SRCS = 4;
    localparam int SYNC_W = 11;
    localparam logic [2:0] DIV_SEL_MAX = 3'h6;
    // APB byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_WAKE = 8'h08;
    localparam logic [7:0] OFS_WDCLR = 8'h0C;
    localparam logic [7:0] OFS_CAUSE = 8'h10;
    // Field positions
    localparam int CTRL_DIV_LSB = 0;
    localparam int CTRL_LCDH_BIT = 3;
    localparam int MODE_HALT_BIT = 0;
    localparam int MODE_STBY_BIT = 1;
    localparam int WAKE_SRC_LSB = 8;
    localparam int CAUSE_WAKE_LSB = 4;
    // Reset values
    localparam logic [2:0] CTRL_DIV_RST = 3'h0;
    localparam logic CTRL_LCDH_RST = 1'b1;
    localparam logic [7:0] WAKE_PIN_RST = 8'h00;
    localparam logic [3:0] WAKE_SRC_RST = 4'h0;
    // Synchroniser reset: pins idle high, reset pin held asserted
    localparam logic [10:0] SYNC_RST = 11'h7F8;
    // Mode codes seen by software
    localparam logic [1:0] MODE_CODE_OPER = 2'h0;
    localparam logic [1:0] MODE_CODE_HALT = 2'h1;
    localparam logic [1:0] MODE_CODE_STBY = 2'h2;
    typedef enum logic [1:0] {ST_OPER, ST_HALT, ST_STBY} pmrs_state_t;
endpackage

// file: pmrs_sync.sv
// Two-flop synchronisers, one per bit.
// Assumes inputs are asynchronous to clk; reset value per bit is a constant.
module pmrs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta;
            // First stage is read by the second stage only
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta <= RST_VAL[i];
                    q[i] <= RST_VAL[i];
                end else begin
                    meta <= d[i];
                    q[i] <= meta;
                end
            end
        end
    endgenerate
endmodule // pmrs_sync

// file: pmrs_clk_div.sv
// Processor clock divider giving a tick every 2**sel cycles.
// Assumes sel is a register on the same clock; codes above 6 act as 6.
module pmrs_clk_div (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [5:0] cnt;
    wire logic [2:0] sel_c = (sel > pmrs_pkg::DIV_SEL_MAX) ? pmrs_pkg::DIV_SEL_MAX : sel;
    wire logic [5:0] limit = (6'h01 << sel_c) - 6'h01;
    wire logic wrap = (cnt >= limit);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 6'h00;
            tick <= 1'b0;
        end else begin
            cnt <= wrap ? 6'h00 : cnt + 6'h01;
            tick <= wrap;
        end
    end
endmodule // pmrs_clk_div

// file: pmrs_pins_model.sv
// Far-side model: wake port pins, reset pin and the 32768 Hz crystal.
// Assumes pclk from the bench; pins idle high through pull-ups.
module pmrs_pins_model #(
    parameter int HALF_NS = 15259
) (
    input wire logic pclk,
    input wire logic osc_run,
    output logic slow_clk,
    output logic [7:0] wake_port_pins,
    output logic ext_rst_n_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        slow_clk = 1'b0;
        wake_port_pins = 8'hFF;
        ext_rst_n_pin = 1'b1;
    end
    // Crystal stands still while disabled
    always begin
        #HALF_NS;
        if (osc_run === 1'b1) slow_clk = ~slow_clk;
    end
    task automatic press(input int idx, input int len);
        @(posedge pclk);
        wake_port_pins[idx] <= 1'b0;
        repeat (len) @(posedge pclk);
        wake_port_pins[idx] <= 1'b1;
    endtask
    task automatic pull_reset(input int len);
        @(posedge pclk);
        ext_rst_n_pin <= 1'b0;
        repeat (len) @(posedge pclk);
        ext_rst_n_pin <= 1'b1;
    endtask
endmodule // pmrs_pins_model

// file: power_mode_reset_supervisor_tb_top.sv
// Self-checking bench for the power-mode and reset supervisor.
// Assumes 8-tick timer; second instance has both build options off.
module power_mode_reset_supervisor_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, lvd_low, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, slow_clk, ext_rst_n_pin;
    logic [7:0] wake_port_pins;
    logic [2:0] wake_evt;
    logic cpu_clk_en, osc32_en, timer_en, lcd_en, io_hold, ram_retain, sys_rst_n, rst_n_bare;
    int num_errors = 0;
    int checks = 0;
    pmrs_top #(.WDT_TICKS(8)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ext_rst_n_pin, .lvd_low, .slow_clk,
        .wake_port_pins, .wake_evt, .cpu_clk_en, .osc32_en, .timer_en, .lcd_en,
        .io_hold, .ram_retain, .sys_rst_n);
    pmrs_top #(.LVR_EN(1'b0), .WDT_EN(1'b0), .WDT_TICKS(8)) DUT2 (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(), .pready(), .pslverr(),
        .ext_rst_n_pin, .lvd_low, .slow_clk, .wake_port_pins, .wake_evt,
        .cpu_clk_en(), .osc32_en(), .timer_en(), .lcd_en(), .io_hold(), .ram_retain(),
        .sys_rst_n(rst_n_bare));
    pmrs_pins_model pins (.pclk, .osc_run(osc32_en), .slow_clk, .wake_port_pins,
        .ext_rst_n_pin);
    task automatic give_verdict();
        if (num_errors == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t %s: %0h not %0h", $time, what, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) chk(pready, 1'b1, "no ready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_rst(input logic v, input int max);
        int n;
        n = 0;
        while (sys_rst_n !== v && n < max) begin
            @(posedge pclk);
            n++;
        end
        if (sys_rst_n !== v) chk(sys_rst_n, v, "reset wait");
    endtask
    // Counts processor clock pulses and reset-low cycles
    task automatic run(input int len, output int hi, output int lows);
        hi = 0;
        lows = 0;
        repeat (len) begin
            @(posedge pclk);
            if (cpu_clk_en === 1'b1) hi++;
            if (sys_rst_n !== 1'b1) lows++;
        end
    endtask
    task automatic t_reset_regs();
        chk({osc32_en, timer_en, lcd_en}, 3'h7, "oper outputs");
        chk({io_hold, ram_retain}, 2'h0, "retention off");
        chk(sys_rst_n, 1'b1, "reset released");
        chk(pready, 1'b1, "ready after reset");
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h8, "ctrl reset");
        apb(1'b0, 8'h20, 32'h0);
        chk(err, 1'b1, "unmapped");
    endtask
    task automatic t_divider();
        int hi, lows;
        apb(1'b1, 8'h0C, 32'h0);
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, 8'h00, 32'h8 | s);
            // Let a period from the old ratio drain first
            run(64, hi, lows);
            run(128, hi, lows);
            chk(hi, 128 >> (s > 6 ? 6 : s), "divide ratio");
        end
        apb(1'b1, 8'h00, 32'h8);
    endtask
    task automatic t_halt();
        int hi, lows;
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, 8'h0C, 32'h0);
            apb(1'b1, 8'h08, 32'h200 << i);
            // Middle pass keeps the display off in halt
            apb(1'b1, 8'h00, (i == 1) ? 32'h0 : 32'h8);
            apb(1'b1, 8'h04, 32'h1);
            run(20, hi, lows);
            chk(hi, 0, "cpu clock in halt");
            chk({osc32_en, timer_en, lcd_en}, (i == 1) ? 32'h6 : 32'h7, "slow side in halt");
            apb(1'b0, 8'h04, 32'h0);
            chk(rd, 32'h1, "halt code");
            wake_evt <= 3'h1 << i;
            @(posedge pclk);
            wake_evt <= 3'h0;
            run(3, hi, lows);
            run(10, hi, lows);
            chk(hi, 10, "resumed");
        end
    endtask
    task automatic t_standby();
        int hi, lows;
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h08, 32'h180);
        apb(1'b1, 8'h04, 32'h3);
        run(1, hi, lows);
        chk({osc32_en, timer_en, lcd_en, cpu_clk_en}, 4'h0, "standby clocks");
        chk({io_hold, ram_retain}, 2'h3, "retention on");
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h2, "standby code");
        // Longer than a full timer period
        run(2600, hi, lows);
        chk(lows, 0, "timer frozen");
        pins.press(0, 10);
        run(10, hi, lows);
        chk(io_hold, 1'b1, "masked pin");
        pins.press(7, 10);
        run(10, hi, lows);
        chk(io_hold, 1'b0, "pin wake");
        apb(1'b0, 8'h10, 32'h0);
        chk(rd & 32'h10, 32'h10, "pin wake seen");
    endtask
    task automatic t_resets();
        int hi, lows;
        lvd_low <= 1'b1;
        wait_rst(1'b0, 8);
        chk(sys_rst_n, 1'b0, "low supply");
        chk(rst_n_bare, 1'b1, "supply option off");
        lvd_low <= 1'b0;
        wait_rst(1'b1, 40);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd & 32'h4, 32'h4, "cause supply");
        // A few slow edges so the restart below has something to clear
        run(700, hi, lows);
        apb(1'b0, 8'h0C, 32'h0);
        chk((rd & 32'hFFFF) != 32'h0, 1'b1, "timer counting");
        pins.pull_reset(5);
        chk(sys_rst_n, 1'b0, "pin reset");
        // Read while the synchronised pin still holds reset
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd & 32'hFFFF, 32'h0, "count after reset");
        wait_rst(1'b1, 40);
    endtask
    task automatic t_wdt();
        int hi, lows;
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 8'h0C, 32'h5A);
            run(1200, hi, lows);
            chk(lows, 0, "cleared in time");
        end
        wait_rst(1'b0, 3000);
        chk(sys_rst_n, 1'b0, "timer expiry");
        chk(rst_n_bare, 1'b1, "timer option off");
        run(pmrs_pkg::RST_HOLD_CYC - 1, hi, lows);
        chk(lows, pmrs_pkg::RST_HOLD_CYC - 1, "stretched reset");
        wait_rst(1'b1, 300);
        apb(1'b0, 8'h10, 32'h0);
        chk(rd & 32'h8, 32'h8, "cause timer");
    endtask
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, lvd_low} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        wake_evt = 3'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wait_rst(1'b1, 20);
        t_reset_regs();
        t_divider();
        t_halt();
        t_standby();
        t_resets();
        t_wdt();
        give_verdict();
    end
    initial begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        give_verdict();
    end
endmodule // power_mode_reset_supervisor_tb_top
